// ---- logic/clr_regs.sv ----
// configuration register bank: minimum system voltage, charge voltage and current limits, input floor
`timescale 1ns/1ps
module clr_regs (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// strap pin, sensed once after power-on reset
	input wire logic [1:0] cell_count_strap_pin,
	// 16-bit register port from the serial engine, 8-bit offset
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// reset events
	input wire logic reg_rst_cmd,
	input wire logic wd_expired,
	// field outputs to the charging loop
	output logic [5:0] min_system_voltage,
	output logic [10:0] charge_voltage_limit,
	output logic [8:0] charge_current_setting,
	output logic [7:0] input_voltage_floor,
	output logic [1:0] msv_reserved,
	output logic reg_rst_busy
);

	// ------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------
	logic [1:0] strap_s1;
	logic [1:0] strap_s2;
	logic strap_done;
	clr_pkg::clr_cells_t cells;
	logic [5:0] msv_def;
	logic [10:0] cvl_def;
	logic [8:0] ccs_def;

	// strap is an external pin: two flops before use
	always_ff @(posedge mclk) begin
		strap_s1 <= cell_count_strap_pin;
		strap_s2 <= strap_s1;
	end

	// cell count is sampled once; later strap moves are ignored
	always_ff @(posedge mclk) begin
		if (srst) begin
			strap_done <= 1'b0;
			cells <= clr_pkg::CELL_1;
		end else if (!strap_done) begin
			strap_done <= 1'b1;
			cells <= clr_pkg::clr_cells_t'(strap_s2);
		end
	end

	clr_default_rom u_rom (
		.cells(cells),
		.msv_def(msv_def),
		.cvl_def(cvl_def),
		.ccs_def(ccs_def)
	);

	// ------------------------------------------------------------
	// write decode and clamps
	// ------------------------------------------------------------
	wire wr_msv = reg_wr && reg_addr == clr_pkg::OFS_MIN_SYS;
	wire wr_cvl = reg_wr && reg_addr == clr_pkg::OFS_CHG_VLIM;
	wire wr_ccs = reg_wr && reg_addr == clr_pkg::OFS_CHG_ILIM;
	wire wr_ivf = reg_wr && reg_addr == clr_pkg::OFS_IN_FLOOR;
	wire [5:0] msv_in = reg_wdata[5:0];
	wire [10:0] cvl_in = reg_wdata[10:0];
	wire [8:0] ccs_in = reg_wdata[8:0];
	// written codes beyond the span are pulled back to its edge
	wire [5:0] msv_clamped = (msv_in > clr_pkg::MSV_CODE_MAX) ? clr_pkg::MSV_CODE_MAX : msv_in;
	wire [10:0] cvl_clamped = (cvl_in < clr_pkg::CVL_CODE_MIN) ? clr_pkg::CVL_CODE_MIN :
		(cvl_in > clr_pkg::CVL_CODE_MAX) ? clr_pkg::CVL_CODE_MAX : cvl_in;
	wire [8:0] ccs_clamped = (ccs_in < clr_pkg::CCS_CODE_MIN) ? clr_pkg::CCS_CODE_MIN :
		(ccs_in > clr_pkg::CCS_CODE_MAX) ? clr_pkg::CCS_CODE_MAX : ccs_in;

	// ------------------------------------------------------------
	// register-reset sequencing
	// ------------------------------------------------------------
	// one cycle of visible busy, then the command bit clears itself
	logic rst_pending;
	wire do_reg_rst = rst_pending;
	always_ff @(posedge mclk) begin
		if (srst) begin
			rst_pending <= 1'b0;
		end else begin
			rst_pending <= reg_rst_cmd && !rst_pending;
		end
	end
	assign reg_rst_busy = rst_pending;

	// ------------------------------------------------------------
	// field storage
	// ------------------------------------------------------------
	// until the strap is sampled, the first cycle holds 1-cell values
	logic load_def;
	always_ff @(posedge mclk) begin
		if (srst) begin
			load_def <= 1'b1;
		end else begin
			load_def <= !strap_done;
		end
	end

	// defaults win over a same-cycle write so reset commands are exact
	always_ff @(posedge mclk) begin
		if (load_def || do_reg_rst) begin
			min_system_voltage <= msv_def;
			charge_voltage_limit <= cvl_def;
		end else begin
			if (wr_msv) begin
				min_system_voltage <= msv_clamped;
			end
			if (wr_cvl) begin
				charge_voltage_limit <= cvl_clamped;
			end
		end
	end

	// charge current is the only field here that the watchdog resets
	always_ff @(posedge mclk) begin
		if (load_def || do_reg_rst || wd_expired) begin
			charge_current_setting <= ccs_def;
		end else if (wr_ccs) begin
			charge_current_setting <= ccs_clamped;
		end
	end

	// reserved pair of the minimum voltage register is plain storage
	always_ff @(posedge mclk) begin
		if (srst) begin
			msv_reserved <= 2'b00;
		end else if (wr_msv) begin
			msv_reserved <= reg_wdata[7:6];
		end
	end

	// input floor survives register reset and watchdog by design
	always_ff @(posedge mclk) begin
		if (srst) begin
			input_voltage_floor <= clr_pkg::IN_FLOOR_RESET;
		end else if (wr_ivf) begin
			input_voltage_floor <= reg_wdata[7:0];
		end
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	// reserved upper bits are zero-extended; unmapped reads give zero
	always_comb begin
		case (reg_addr)
			clr_pkg::OFS_MIN_SYS: reg_rdata = {8'h00, msv_reserved, min_system_voltage};
			clr_pkg::OFS_CHG_VLIM: reg_rdata = {5'h00, charge_voltage_limit};
			clr_pkg::OFS_CHG_ILIM: reg_rdata = {7'h00, charge_current_setting};
			clr_pkg::OFS_IN_FLOOR: reg_rdata = {8'h00, input_voltage_floor};
			default: reg_rdata = 16'h0000;
		endcase
	end

endmodule : clr_regs

// ---- logic/clr_pkg.sv ----
// package: offsets, field layouts, codes and defaults of the charger limit registers
package clr_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_MIN_SYS = 8'h00;
	localparam logic [7:0] OFS_CHG_VLIM = 8'h01;
	localparam logic [7:0] OFS_CHG_ILIM = 8'h03;
	localparam logic [7:0] OFS_IN_FLOOR = 8'h05;

	// ------------------------------------------------------------
	// field widths and scaling
	// ------------------------------------------------------------
	localparam int MSV_W = 6;
	localparam int CVL_W = 11;
	localparam int CCS_W = 9;
	localparam int MSV_OFFSET_MV = 2500;
	localparam int MSV_STEP_MV = 250;
	localparam int MSV_MAX_MV = 16000;
	localparam int CVL_STEP_MV = 10;
	localparam int CVL_MIN_MV = 3000;
	localparam int CVL_MAX_MV = 18800;
	localparam int CCS_STEP_MA = 10;
	localparam int CCS_MIN_MA = 50;
	localparam int CCS_MAX_MA = 5000;

	// highest legal minimum system voltage code
	localparam logic [5:0] MSV_CODE_MAX = 6'((MSV_MAX_MV - MSV_OFFSET_MV) / MSV_STEP_MV);
	localparam logic [10:0] CVL_CODE_MIN = 11'(CVL_MIN_MV / CVL_STEP_MV);
	localparam logic [10:0] CVL_CODE_MAX = 11'(CVL_MAX_MV / CVL_STEP_MV);
	localparam logic [8:0] CCS_CODE_MIN = 9'(CCS_MIN_MA / CCS_STEP_MA);
	localparam logic [8:0] CCS_CODE_MAX = 9'(CCS_MAX_MA / CCS_STEP_MA);

	// ------------------------------------------------------------
	// power-on defaults, strap-dependent except the input floor
	// ------------------------------------------------------------
	localparam int MSV_DEF_MV [4] = '{3500, 7000, 9000, 12000};
	localparam int CVL_DEF_MV [4] = '{4200, 8400, 12600, 16800};
	localparam int CCS_DEF_LO_CELL_MA = 2000;
	localparam int CCS_DEF_HI_CELL_MA = 1000;
	localparam logic [7:0] IN_FLOOR_RESET = 8'h24;

	// cell count as sensed from the strap, 1 to 4 cells
	typedef enum logic [1:0] {CELL_1, CELL_2, CELL_3, CELL_4} clr_cells_t;

endpackage : clr_pkg

// ---- logic/clr_default_rom.sv ----
// strap-indexed default code table for the charger limits
`timescale 1ns/1ps
module clr_default_rom (
	// strap selection
	input wire clr_pkg::clr_cells_t cells,
	// default codes
	output logic [5:0] msv_def,
	output logic [10:0] cvl_def,
	output logic [8:0] ccs_def
);

	// codes for each cell count, derived from the millivolt figures
	assign msv_def = 6'((clr_pkg::MSV_DEF_MV[cells] - clr_pkg::MSV_OFFSET_MV) / clr_pkg::MSV_STEP_MV);
	assign cvl_def = 11'(clr_pkg::CVL_DEF_MV[cells] / clr_pkg::CVL_STEP_MV);
	// one or two cells take the higher current
	assign ccs_def = (cells == clr_pkg::CELL_1 || cells == clr_pkg::CELL_2) ?
		9'(clr_pkg::CCS_DEF_LO_CELL_MA / clr_pkg::CCS_STEP_MA) :
		9'(clr_pkg::CCS_DEF_HI_CELL_MA / clr_pkg::CCS_STEP_MA);

endmodule : clr_default_rom

// ---- tb/clr_regs_properties.sv ----
// checker: timing and value properties of the limit register bank
`timescale 1ns/1ps
module clr_regs_properties (
	// clock, reset, strobes
	input wire logic mclk,
	input wire logic srst,
	input wire logic reg_wr,
	input wire logic reg_rst_cmd,
	input wire logic wd_expired,
	input wire logic reg_rst_busy,
	// strap and register port
	input wire logic [1:0] cell_count_strap_pin,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	// field outputs
	input wire logic [5:0] min_system_voltage,
	input wire logic [10:0] charge_voltage_limit,
	input wire logic [8:0] charge_current_setting,
	input wire logic [7:0] input_voltage_floor
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// fields take their strap defaults at the second edge after release, so range checks wait
	property p_msv; !$past(srst, 2) |-> min_system_voltage <= 6'h36; endproperty
	a_msv: assert property (p_msv) else $error("min system code too high");
	property p_ccs; !$past(srst, 2) |-> charge_current_setting >= 9'h005; endproperty
	a_ccs: assert property (p_ccs) else $error("charge current code too low");
	property p_por; $fell(srst) && cell_count_strap_pin == 2'h0 |-> ##2 min_system_voltage == 6'h04; endproperty
	a_por: assert property (p_por) else $error("one cell default wrong");
	property p_flr; reg_addr == 8'h05 |-> reg_rdata == {8'h00, input_voltage_floor}; endproperty
	a_flr: assert property (p_flr) else $error("floor read wrong");
	property p_flw; reg_wr && reg_addr == 8'h05 |=> {8'h00, input_voltage_floor} == ($past(reg_wdata) & 16'h00ff);
	endproperty
	a_flw: assert property (p_flw) else $error("floor write lost");
	property p_rs1; reg_addr == 8'h01 |-> reg_rdata[15:11] == 5'h00; endproperty
	a_rs1: assert property (p_rs1) else $error("reserved bits set");
	property p_rs3; reg_addr == 8'h03 |-> reg_rdata[15:9] == 7'h00; endproperty
	a_rs3: assert property (p_rs3) else $error("reserved bits set");
	property p_busy; reg_rst_cmd && !reg_rst_busy |=> reg_rst_busy ##1 !reg_rst_busy; endproperty
	a_busy: assert property (p_busy) else $error("command bit not self clearing");
	property p_rdef; reg_rst_busy && cell_count_strap_pin == 2'h3 |=> charge_voltage_limit == 11'h690; endproperty
	a_rdef: assert property (p_rdef) else $error("voltage default not restored");
	property p_wd; wd_expired && cell_count_strap_pin[1] |-> ##[1:2] charge_current_setting == 9'h064; endproperty
	a_wd: assert property (p_wd) else $error("current default not restored");
	c_rst: cover property (reg_rst_busy);
	c_wd: cover property (wd_expired);
	c_flw: cover property (reg_wr && reg_addr == 8'h05);
endmodule : clr_regs_properties
bind clr_regs clr_regs_properties clr_regs_properties_i (.mclk, .srst, .reg_wr, .reg_rst_cmd, .wd_expired,
	.reg_rst_busy, .cell_count_strap_pin, .reg_addr, .reg_wdata, .reg_rdata, .min_system_voltage,
	.charge_voltage_limit, .charge_current_setting, .input_voltage_floor);

// ---- tb/clr_host.sv ----
// host model: writes and reads through the assembled register port
`timescale 1ns/1ps
module clr_host (
	// clock
	input wire logic mclk,
	// register port
	output logic reg_wr,
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
	end
	// data inverted once released so nothing rides on a stale value
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk) #1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge mclk) #1;
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask : wr
	// read data is taken at the edge that closes the address cycle, then the port moves on
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk) #1;
		reg_addr = a;
		@(posedge mclk);
		d = reg_rdata;
		#1;
	endtask : rd
endmodule : clr_host

// ---- tb/tb.sv ----
// testbench: strap defaults, clamped writes, reset command, watchdog restore
`timescale 1ns/1ps
module tb;
	logic mclk, srst, reg_rst_cmd, wd_expired, reg_wr, reg_rst_busy;
	logic [1:0] cell_count_strap_pin;
	logic [7:0] reg_addr, input_voltage_floor, a;
	logic [15:0] reg_wdata, reg_rdata, rv, d;
	logic [31:0] seed = 32'h0000_3f87;
	int miscompares = 0, checks = 0, cyc = 0;
	clr_regs clr_regs_i (.mclk(mclk), .srst(srst), .cell_count_strap_pin(cell_count_strap_pin), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rst_cmd(reg_rst_cmd),
		.wd_expired(wd_expired), .min_system_voltage(), .charge_voltage_limit(), .charge_current_setting(),
		.input_voltage_floor(input_voltage_floor), .msv_reserved(), .reg_rst_busy(reg_rst_busy));
	clr_host clr_host_i (.mclk(mclk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// run is a few hundred cycles; a hang ends here
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			summarize();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction : xs
	// read value expected after writing d to a
	function automatic logic [15:0] exp_rd(input logic [7:0] a, input logic [15:0] d);
		case (a)
			8'h00: return {8'h00, d[7:6], (d[5:0] > 6'h36) ? 6'h36 : d[5:0]};
			8'h01: return {5'h00, (d[10:0] < 11'h12c) ? 11'h12c : (d[10:0] > 11'h758) ? 11'h758 : d[10:0]};
			8'h03: return {7'h00, (d[8:0] < 9'h005) ? 9'h005 : (d[8:0] > 9'h1f4) ? 9'h1f4 : d[8:0]};
			8'h05: return {8'h00, d[7:0]};
			default: return 16'h0000;
		endcase
	endfunction : exp_rd
	function automatic logic [15:0] dflt(input logic [7:0] a, input int s);
		case (a)
			8'h00: return 16'((clr_pkg::MSV_DEF_MV[s] - clr_pkg::MSV_OFFSET_MV) / clr_pkg::MSV_STEP_MV);
			8'h01: return 16'(clr_pkg::CVL_DEF_MV[s] / clr_pkg::CVL_STEP_MV);
			default: return 16'((s < 2 ? clr_pkg::CCS_DEF_LO_CELL_MA : clr_pkg::CCS_DEF_HI_CELL_MA) / clr_pkg::CCS_STEP_MA);
		endcase
	endfunction : dflt
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp
	task automatic chk(input logic [7:0] a, input logic [15:0] e);
		clr_host_i.rd(a, rv);
		cmp(rv, e);
	endtask : chk
	task automatic summarize();
		if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	initial begin
		srst = 1'b1;
		reg_rst_cmd = 1'b0;
		wd_expired = 1'b0;
		// each strap setting gets its own power-on reset
		for (int s = 0; s < 4; s++) begin
			cell_count_strap_pin = 2'(s);
			srst = 1'b1;
			repeat (3) @(posedge mclk);
			#1 srst = 1'b0;
			repeat (3) @(posedge mclk);
			chk(8'h00, dflt(8'h00, s));
			chk(8'h01, dflt(8'h01, s));
			chk(8'h03, dflt(8'h03, s));
			chk(8'h05, 16'h0024);
		end
		clr_host_i.wr(8'h03, 16'h0001);
		chk(8'h03, 16'h0005);
		clr_host_i.wr(8'h05, 16'h5aa5);
		chk(8'h05, 16'h00a5);
		// random offsets 0..7, every third data all zeros or all ones
		for (int i = 0; i < 40; i++) begin
			seed = xs(seed);
			a = {5'h00, seed[10:8]};
			d = (i % 3 == 0) ? {16{seed[31]}} : seed[31:16];
			clr_host_i.wr(a, d);
			chk(a, exp_rd(a, d));
		end
		clr_host_i.wr(8'h00, 16'h0003);
		clr_host_i.wr(8'h03, 16'h0100);
		@(posedge mclk) #1 reg_rst_cmd = 1'b1;
		@(posedge mclk) #1 reg_rst_cmd = 1'b0;
		cmp({15'h0000, reg_rst_busy}, 16'h0001);
		chk(8'h00, dflt(8'h00, 3));
		chk(8'h01, dflt(8'h01, 3));
		chk(8'h03, dflt(8'h03, 3));
		cmp({15'h0000, reg_rst_busy}, 16'h0000);
		clr_host_i.wr(8'h00, 16'h0011);
		clr_host_i.wr(8'h03, 16'h0123);
		@(posedge mclk) #1 wd_expired = 1'b1;
		@(posedge mclk) #1 wd_expired = 1'b0;
		chk(8'h03, dflt(8'h03, 3));
		chk(8'h00, 16'h0011);
		summarize();
	end
endmodule : tb
